// ---- inc/cdr_lock_pkg.sv ----
package cdr_lock_pkg;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef logic [7:0]         byte_t;
	typedef logic [11:0]        vco_code_t;
	typedef logic signed [5:0]  phase_t;
	typedef logic signed [14:0] diff_t;

	typedef enum logic [0:0] {
		ST_ACQUIRE = 1'b0,
		ST_TRACK   = 1'b1
	} lock_state_e;

	// ---------------------------------------------------------------
	// register offsets
	// ---------------------------------------------------------------
	localparam byte_t ADDR_CTRL_A     = 8'h00;
	localparam byte_t ADDR_CTRL_B     = 8'h01;
	localparam byte_t ADDR_CTRL_C     = 8'h02;
	localparam byte_t ADDR_MISC       = 8'h03;
	localparam byte_t ADDR_PHASE      = 8'h04;
	localparam byte_t ADDR_IRQ_STATUS = 8'h05;
	localparam byte_t ADDR_IRQ_MASK   = 8'h06;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int A_REF_MODE    = 0;
	localparam int A_RATIO_LO    = 2;
	localparam int A_RATIO_HI    = 5;
	localparam int A_RANGE_LO    = 6;
	localparam int A_RANGE_HI    = 7;
	localparam int B_STICKY_CLR  = 6;
	localparam int B_PIN_STATIC  = 7;
	localparam int C_LOS_POL     = 2;
	localparam int M_ACQUIRING   = 0;
	localparam int M_SIG_ABSENT  = 1;
	localparam int M_STICKY_LOSS = 4;
	localparam int I_LOSS        = 0;
	localparam int I_LOCK        = 1;
	localparam int I_HARMONIC    = 2;
	localparam int I_SIG_ABSENT  = 3;
	localparam byte_t CTRL_RESET  = 8'h00;
	localparam byte_t MASK_RESET  = 8'h00;
	localparam phase_t PHASE_RESET = 6'h00;

	// ---------------------------------------------------------------
	// frequency thresholds
	// ---------------------------------------------------------------
	localparam int RATE_MIN_MBPS   = 10;
	localparam int RATE_MAX_MBPS   = 2700;
	localparam int VCO_BOTTOM_MHZ  = 10;
	localparam vco_code_t VCO_BOTTOM = 12'h000;
	localparam vco_code_t VCO_TOP    = 12'hFFF;
	localparam int TIGHT_PPM       = 250;
	localparam int WIDE_PPM        = 1000;
	localparam int MTR_WINDOW      = 4096;
	localparam int TIGHT_DIFF_I    = MTR_WINDOW * TIGHT_PPM / 1000000;
	localparam int WIDE_DIFF_I     = MTR_WINDOW * WIDE_PPM / 1000000;
	localparam diff_t TIGHT_DIFF   = diff_t'(TIGHT_DIFF_I);
	localparam diff_t WIDE_DIFF    = diff_t'(WIDE_DIFF_I);
	localparam int STEP_SHIFT      = 2;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int LOS_TIME_NS    = 450;
	localparam int LOS_CYCLES_I   = (LOS_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam logic [6:0] LOS_CYCLES = 7'(LOS_CYCLES_I);
	localparam int HARM_TRANSITIONS = 16384;

	// ---------------------------------------------------------------
	// sample phase
	// ---------------------------------------------------------------
	localparam int PHASE_STEP_DEG = 6;
	localparam int HALF_UI_DEG    = 180;
	localparam phase_t PHASE_LIMIT = phase_t'(HALF_UI_DEG / PHASE_STEP_DEG);

endpackage

// ---- core/lock_freq_meter.sv ----
`timescale 1ns/1ps
module lock_freq_meter (
	input  wire logic                clock_i,
	input  wire logic                rst_i,
	input  wire logic                restart_i,
	input  wire logic                ref_tick_i,
	input  wire logic                meas_tick_i,
	output logic                     done_o,
	output cdr_lock_pkg::diff_t      diff_o
);
	import cdr_lock_pkg::*;

	// ---------------------------------------------------------------
	// window of reference ticks, measured ticks counted inside it
	// ---------------------------------------------------------------
	logic [12:0] ref_cnt;
	logic [13:0] meas_cnt;
	logic [13:0] meas_now;
	logic        window_end;

	assign meas_now   = (meas_tick_i && meas_cnt != 14'h3FFF) ?
		meas_cnt + 14'h0001 : meas_cnt;
	assign window_end = ref_tick_i && ref_cnt == 13'(MTR_WINDOW - 1);

	always_ff @(posedge clock_i) begin
		if (rst_i || restart_i) begin
			ref_cnt  <= 13'h0000;
			meas_cnt <= 14'h0000;
		end else if (window_end) begin
			ref_cnt  <= 13'h0000;
			meas_cnt <= 14'h0000;
		end else begin
			if (ref_tick_i)
				ref_cnt <= ref_cnt + 13'h0001;
			meas_cnt <= meas_now;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			done_o <= 1'b0;
			diff_o <= 15'h0000;
		end else begin
			done_o <= window_end && !restart_i;
			if (window_end)
				diff_o <= diff_t'({1'b0, meas_now}) - diff_t'(MTR_WINDOW);
		end
	end

endmodule

// ---- core/cdr_lock_status.sv ----
`timescale 1ns/1ps
// Operation
// - without reference, acquire any rate 10 Mbps to 2.7 Gbps from data
// - free mode: indicator drops inside 250 ppm, then phase loop finishes
// - locked, error over 1000 ppm: reassert, restart from VCO bottom
// - reference-assisted lock only while control_reg_a bit 0 is one
// - reference mode compares divided VCO to divided reference, 250 ppm
// - reference mode, error over 1000 ppm: reassert, reacquire on reference
// - sticky loss bit [4] set on any loss, held after relock
// - write one then zero to control_reg_b[6] clears sticky bit
// - control_reg_b[7] one: pin mirrors sticky; zero: pin shows acquisition
// - lower harmonic detected: assert pin, reacquire, lock, release pin
// - higher harmonic ignored by detector, caught as ordinary lock loss
// - harmonic decision after 16384 data transitions without short runs
// - harmonic detector disabled in reference-assisted mode
// - low input level asserts signal-absent flag after 450 ns
// - signal-absent pin active high, control_reg_c[2] one makes it low
// - sample offset within half a UI either side, 6 degree steps
module cdr_lock_status #(
	parameter int HARM_COUNT = cdr_lock_pkg::HARM_TRANSITIONS
) (
	input  wire logic                clock_i,
	input  wire logic                rst_i,
	input  wire cdr_lock_pkg::byte_t reg_addr_i,
	input  wire cdr_lock_pkg::byte_t reg_wdata_i,
	input  wire logic                reg_write_i,
	input  wire logic                reg_read_i,
	output cdr_lock_pkg::byte_t      reg_rdata_o,
	input  wire logic                vco_tick_i,
	input  wire logic                data_tick_i,
	input  wire logic                ref_tick_i,
	input  wire logic                bit_strobe_i,
	input  wire logic                data_edge_i,
	input  wire logic                level_low_i,
	output cdr_lock_pkg::vco_code_t  vco_code_o,
	output logic                     freq_loop_on_o,
	output logic                     lock_loss_indicator_o,
	output logic                     signal_absent_flag_o,
	output cdr_lock_pkg::phase_t     sample_offset_o,
	output logic                     irq_o
);
	import cdr_lock_pkg::*;

	localparam int LOS_BOUND = 95;

	function automatic diff_t abs_diff(input diff_t d);
		abs_diff = d[14] ? -d : d;
	endfunction

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	byte_t       control_reg_a;
	byte_t       control_reg_b;
	byte_t       control_reg_c;
	byte_t       irq_mask;
	logic [3:0]  irq_status;
	phase_t      phase_set;
	logic        clr_prev;
	logic        sticky_loss;
	lock_state_e state;
	logic        ref_mode;
	logic        clear_seq;
	logic        loss_event;
	logic        lock_gain;
	logic        harm_hit;
	logic        los_flag;
	logic        los_rise;

	assign ref_mode  = control_reg_a[A_REF_MODE];
	assign clear_seq = clr_prev && !control_reg_b[B_STICKY_CLR];

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			control_reg_a <= CTRL_RESET;
			control_reg_b <= CTRL_RESET;
			control_reg_c <= CTRL_RESET;
			irq_mask      <= MASK_RESET;
			phase_set     <= PHASE_RESET;
		end else if (reg_write_i) begin
			unique case (reg_addr_i)
				ADDR_CTRL_A:   control_reg_a <= reg_wdata_i;
				ADDR_CTRL_B:   control_reg_b <= reg_wdata_i;
				ADDR_CTRL_C:   control_reg_c <= reg_wdata_i;
				ADDR_IRQ_MASK: irq_mask <= reg_wdata_i;
				ADDR_PHASE:    phase_set <= phase_t'(reg_wdata_i[5:0]);
				default:       ;
			endcase
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			clr_prev <= 1'b0;
		else
			clr_prev <= control_reg_b[B_STICKY_CLR];
	end

	// ---------------------------------------------------------------
	// read port
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_read_i) begin
			unique case (reg_addr_i)
				ADDR_CTRL_A:     reg_rdata_o <= control_reg_a;
				ADDR_CTRL_B:     reg_rdata_o <= control_reg_b;
				ADDR_CTRL_C:     reg_rdata_o <= control_reg_c;
				ADDR_MISC:       reg_rdata_o <= {3'h0, sticky_loss, 2'h0,
					los_flag, state == ST_ACQUIRE};
				ADDR_PHASE:      reg_rdata_o <= {2'h0, phase_set};
				ADDR_IRQ_STATUS: reg_rdata_o <= {4'h0, irq_status};
				ADDR_IRQ_MASK:   reg_rdata_o <= irq_mask;
				default:         reg_rdata_o <= 8'h00;
			endcase
		end else begin
			reg_rdata_o <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// interrupt status, cleared by reading it, set wins
	// ---------------------------------------------------------------
	logic [3:0] irq_set;
	logic       irq_read;

	assign irq_set  = {los_rise, harm_hit, lock_gain, loss_event};
	assign irq_read = reg_read_i && reg_addr_i == ADDR_IRQ_STATUS;

	always_ff @(posedge clock_i) begin
		if (rst_i)
			irq_status <= 4'h0;
		else
			irq_status <= (irq_read ? 4'h0 : irq_status) | irq_set;
	end

	assign irq_o = |(irq_status & irq_mask[3:0]);

	// ---------------------------------------------------------------
	// frequency comparison source
	// ---------------------------------------------------------------
	logic [3:0] vco_div_cnt;
	logic [1:0] ref_div_cnt;
	logic       vco_div_tick;
	logic       ref_div_tick;
	logic       meas_tick;
	logic       targ_tick;
	logic       mtr_restart;
	logic       mtr_done;
	diff_t      mtr_diff;
	logic       mode_prev;

	// divide ratio and range are taken as programmed by the host
	assign vco_div_tick = vco_tick_i &&
		vco_div_cnt == control_reg_a[A_RATIO_HI:A_RATIO_LO];
	assign ref_div_tick = ref_tick_i &&
		ref_div_cnt == control_reg_a[A_RANGE_HI:A_RANGE_LO];

	always_ff @(posedge clock_i) begin
		if (rst_i || !ref_mode) begin
			vco_div_cnt <= 4'h0;
			ref_div_cnt <= 2'h0;
		end else begin
			if (vco_tick_i)
				vco_div_cnt <= vco_div_tick ? 4'h0 : vco_div_cnt + 4'h1;
			if (ref_tick_i)
				ref_div_cnt <= ref_div_tick ? 2'h0 : ref_div_cnt + 2'h1;
		end
	end

	assign meas_tick = ref_mode ? vco_div_tick : vco_tick_i;
	assign targ_tick = ref_mode ? ref_div_tick : data_tick_i;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mode_prev   <= 1'b0;
			mtr_restart <= 1'b1;
		end else begin
			mode_prev   <= ref_mode;
			mtr_restart <= loss_event || lock_gain || mode_prev != ref_mode;
		end
	end

	lock_freq_meter meter (
		.clock_i     (clock_i),
		.rst_i       (rst_i),
		.restart_i   (mtr_restart),
		.ref_tick_i  (targ_tick),
		.meas_tick_i (meas_tick),
		.done_o      (mtr_done),
		.diff_o      (mtr_diff)
	);

	// ---------------------------------------------------------------
	// lock state and frequency loop
	// ---------------------------------------------------------------
	diff_t     err_mag;
	vco_code_t step;
	logic [12:0] vco_sum;

	assign err_mag   = abs_diff(mtr_diff);
	assign lock_gain = state == ST_ACQUIRE && mtr_done &&
		err_mag <= TIGHT_DIFF;
	assign loss_event = state == ST_TRACK &&
		((mtr_done && err_mag > WIDE_DIFF) || harm_hit);
	assign step = (err_mag >>> STEP_SHIFT) == 15'h0000 ? 12'h001 :
		vco_code_t'(err_mag >>> STEP_SHIFT);
	assign vco_sum = {1'b0, vco_code_o} + {1'b0, step};

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state <= ST_ACQUIRE;
		end else begin
			unique case (state)
				ST_ACQUIRE: if (lock_gain) state <= ST_TRACK;
				ST_TRACK:   if (loss_event) state <= ST_ACQUIRE;
			endcase
		end
	end

	// coarse search from the bottom, steps shrink with the error
	always_ff @(posedge clock_i) begin
		if (rst_i || loss_event) begin
			vco_code_o <= VCO_BOTTOM;
		end else if (state == ST_ACQUIRE && mtr_done && !lock_gain) begin
			if (mtr_diff[14])
				vco_code_o <= vco_sum[12] ? VCO_TOP : vco_sum[11:0];
			else if (vco_code_o != VCO_BOTTOM)
				vco_code_o <= vco_code_o - 12'h001;
		end
	end

	// phase loop owns the VCO once the frequency loop lets go
	assign freq_loop_on_o = state == ST_ACQUIRE;

	// ---------------------------------------------------------------
	// sticky loss bit and lock pin
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i)
			sticky_loss <= 1'b0;
		else if (loss_event)
			sticky_loss <= 1'b1;
		else if (clear_seq)
			sticky_loss <= 1'b0;
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			lock_loss_indicator_o <= 1'b1;
		else if (control_reg_b[B_PIN_STATIC])
			lock_loss_indicator_o <= sticky_loss;
		else
			lock_loss_indicator_o <= state == ST_ACQUIRE;
	end

	// ---------------------------------------------------------------
	// lower harmonic detector
	// ---------------------------------------------------------------
	// a lower harmonic never shows a one-bit run at the locked rate
	logic [1:0]  run_len;
	logic [14:0] harm_cnt;
	logic        harm_arm;

	assign harm_arm = state == ST_TRACK && !ref_mode;
	assign harm_hit = harm_arm && bit_strobe_i && data_edge_i &&
		run_len != 2'h1 && harm_cnt == 15'(HARM_COUNT - 1);

	always_ff @(posedge clock_i) begin
		if (rst_i || !harm_arm) begin
			run_len  <= 2'h2;
			harm_cnt <= 15'h0000;
		end else if (bit_strobe_i) begin
			if (data_edge_i) begin
				run_len <= 2'h1;
				if (run_len == 2'h1 || harm_hit)
					harm_cnt <= 15'h0000;
				else
					harm_cnt <= harm_cnt + 15'h0001;
			end else if (run_len != 2'h3) begin
				run_len <= run_len + 2'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// signal-absent filter and polarity
	// ---------------------------------------------------------------
	logic       lvl_s1;
	logic       lvl_s2;
	logic       lvl_s3;
	logic [6:0] los_cnt;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			lvl_s1 <= 1'b0;
			lvl_s2 <= 1'b0;
			lvl_s3 <= 1'b0;
		end else begin
			lvl_s1 <= level_low_i;
			lvl_s2 <= lvl_s1;
			lvl_s3 <= lvl_s2;
		end
	end

	assign los_rise = lvl_s2 == lvl_s3 && lvl_s3 && !los_flag &&
		los_cnt == LOS_CYCLES - 7'h01;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			los_cnt  <= 7'h00;
			los_flag <= 1'b0;
		end else if (lvl_s2 != lvl_s3) begin
			los_cnt <= los_cnt;
		end else if (lvl_s3 == los_flag) begin
			los_cnt <= 7'h00;
		end else if (los_cnt == LOS_CYCLES - 7'h01) begin
			los_cnt  <= 7'h00;
			los_flag <= lvl_s3;
		end else begin
			los_cnt <= los_cnt + 7'h01;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i)
			signal_absent_flag_o <= 1'b0;
		else
			signal_absent_flag_o <= los_flag ^ control_reg_c[C_LOS_POL];
	end

	// ---------------------------------------------------------------
	// sample phase offset
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i)
			sample_offset_o <= PHASE_RESET;
		else if (phase_set > PHASE_LIMIT)
			sample_offset_o <= PHASE_LIMIT;
		else if (phase_set < -PHASE_LIMIT)
			sample_offset_o <= -PHASE_LIMIT;
		else
			sample_offset_o <= phase_set;
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence seq_clear;
		control_reg_b[B_STICKY_CLR] ##1 !control_reg_b[B_STICKY_CLR];
	endsequence

	sequence seq_loss_restart;
		state == ST_ACQUIRE && vco_code_o == VCO_BOTTOM;
	endsequence

	a_sticky_on_loss: assert property (@(posedge clock_i) disable iff (rst_i)
		loss_event |=> sticky_loss [*2])
		else $error("sticky loss bit not held after loss");

	a_sticky_clear_seq: assert property (@(posedge clock_i) disable iff (rst_i)
		(seq_clear ##0 !loss_event) |=> !sticky_loss)
		else $error("sticky loss bit not cleared");

	a_restart_bottom: assert property (@(posedge clock_i) disable iff (rst_i)
		loss_event |=> seq_loss_restart ##2 lock_loss_indicator_o ||
			control_reg_b[B_PIN_STATIC])
		else $error("acquisition did not restart at bottom");

	a_lock_on_tight: assert property (@(posedge clock_i) disable iff (rst_i)
		(state == ST_ACQUIRE && mtr_done && abs_diff(mtr_diff) <= TIGHT_DIFF)
		|=> state == ST_TRACK && !freq_loop_on_o)
		else $error("no lock inside tight tolerance");

	a_pin_static_mirror: assert property (@(posedge clock_i) disable iff (rst_i)
		control_reg_b[B_PIN_STATIC] |=> lock_loss_indicator_o == $past(sticky_loss))
		else $error("lock pin does not mirror sticky bit");

	a_harm_disabled: assert property (@(posedge clock_i) disable iff (rst_i)
		ref_mode [*2] |-> harm_cnt == 15'h0000 && !harm_hit)
		else $error("harmonic detector active in reference mode");

	a_los_response: assert property (@(posedge clock_i) disable iff (rst_i)
		(!los_flag && level_low_i) [*1] ##1 level_low_i [*8] |->
			##[0:LOS_BOUND] los_flag || !level_low_i)
		else $error("signal-absent flag late");

	a_los_polarity: assert property (@(posedge clock_i) disable iff (rst_i)
		##1 signal_absent_flag_o == ($past(los_flag) ^
			$past(control_reg_c[C_LOS_POL])))
		else $error("signal-absent polarity wrong");

	a_phase_bounded: assert property (@(posedge clock_i) disable iff (rst_i)
		sample_offset_o <= PHASE_LIMIT && sample_offset_o >= -PHASE_LIMIT)
		else $error("sample offset beyond half a unit interval");

endmodule

// ---- verif/cdr_front_model.sv ----
`timescale 1ns/1ps
module cdr_front_model (
	input  wire logic        clock_i,
	input  wire logic        rst_i,
	input  wire logic [11:0] vco_code_i,
	input  wire logic [11:0] data_inc_i,
	input  wire logic        harm_i,
	output logic             vco_tick_o,
	output logic             data_tick_o,
	output logic             ref_tick_o,
	output logic             bit_strobe_o,
	output logic             data_edge_o
);
	logic [12:0] vacc;
	logic [12:0] dacc;
	logic        half;

	// -------------------------------------------
	// rates as carries of phase accumulators
	// -------------------------------------------
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			vacc <= '0;
			dacc <= '0;
			half <= 1'b0;
		end else begin
			vacc <= {1'b0, vacc[11:0]} + {1'b0, vco_code_i};
			dacc <= {1'b0, dacc[11:0]} + {1'b0, data_inc_i};
			half <= ~half;
		end
	end

	assign vco_tick_o   = vacc[12];
	assign data_tick_o  = dacc[12];
	assign ref_tick_o   = dacc[12];
	assign bit_strobe_o = ~rst_i;
	// two-bit runs look like a lower harmonic of the locked rate
	assign data_edge_o  = harm_i ? half : 1'b1;
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import cdr_lock_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	byte_t       addr = '0;
	byte_t       wdata = '0;
	logic        wr_s = 1'b0;
	logic        rd_s = 1'b0;
	logic        lvl = 1'b0;
	logic        harm = 1'b0;
	logic [11:0] dinc = 12'h400;
	byte_t       rdata;
	vco_code_t   vco;
	phase_t      offs;
	logic        floop, pin, sabs, irq, vt, dt, rt, bs, de;
	int          errors = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          seed = 96505;
	byte_t       exp_q[$];
	logic        rd_seen = 1'b0;

	always #2.5 clk = ~clk;

	cdr_lock_status #(.HARM_COUNT(16)) dut (
		.clock_i(clk), .rst_i(rst), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
		.reg_rdata_o(rdata), .vco_tick_i(vt), .data_tick_i(dt),
		.ref_tick_i(rt), .bit_strobe_i(bs), .data_edge_i(de),
		.level_low_i(lvl), .vco_code_o(vco), .freq_loop_on_o(floop),
		.lock_loss_indicator_o(pin), .signal_absent_flag_o(sabs),
		.sample_offset_o(offs), .irq_o(irq)
	);

	cdr_front_model front (
		.clock_i(clk), .rst_i(rst), .vco_code_i(vco), .data_inc_i(dinc),
		.harm_i(harm), .vco_tick_o(vt), .data_tick_o(dt), .ref_tick_o(rt),
		.bit_strobe_o(bs), .data_edge_o(de)
	);

	// -------------------------------------------
	// checking and bus tasks
	// -------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input byte_t a, input byte_t d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask

	task automatic rd(input byte_t a, input byte_t e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_s <= 1'b0;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic wait_loop(input logic want, input int lim);
		int i;
		i = 0;
		while (floop !== want && i < lim) begin
			@(negedge clk);
			i++;
		end
		chk(floop, want);
	endtask

	function automatic phase_t clamp(input phase_t v);
		if (v > PHASE_LIMIT)
			return PHASE_LIMIT;
		if (v < -PHASE_LIMIT)
			return -PHASE_LIMIT;
		return v;
	endfunction

	task automatic summarize;
		$display("errors=%0d checks=%0d", errors, n_checks);
		if (errors == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// read data stands only in the cycle after the strobe
	always @(posedge clk) rd_seen <= rd_s;
	always @(negedge clk) begin
		if (rd_seen)
			chk(rdata, exp_q.pop_front());
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 99000) begin
			errors++;
			summarize();
		end
	end

	// -------------------------------------------
	// scenarios
	// -------------------------------------------
	initial begin
		byte_t v;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int a = 0; a < 8; a++)
			rd(byte_t'(a), (a == 3) ? 8'h01 : 8'h00);
		wr(ADDR_MISC, 8'hFF);
		rd(ADDR_MISC, 8'h01);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 8'h1F : (i == 1) ? 8'h21 : byte_t'($random(seed));
			v = v & 8'h3F;
			wr(ADDR_PHASE, v);
			rd(ADDR_PHASE, v);
			cycles(1);
			chk(offs, clamp(phase_t'(v[5:0])));
		end
		@(posedge clk) lvl <= 1'b1;
		cycles(80);
		chk(sabs, 1'b0);
		cycles(20);
		chk(sabs, 1'b1);
		wr(ADDR_IRQ_MASK, 8'h08);
		cycles(2);
		chk(irq, 1'b1);
		rd(ADDR_IRQ_STATUS, 8'h08);
		cycles(2);
		chk(irq, 1'b0);
		wr(ADDR_CTRL_C, 8'h04);
		cycles(2);
		chk(sabs, 1'b0);
		rd(ADDR_MISC, 8'h03);
		@(posedge clk) lvl <= 1'b0;
		cycles(100);
		chk(sabs, 1'b1);
		wr(ADDR_CTRL_C, 8'h00);
		wr(ADDR_IRQ_MASK, 8'h00);
		wait_loop(1'b0, 40000);
		cycles(2);
		chk(pin, 1'b0);
		rd(ADDR_IRQ_STATUS, 8'h02);
		wr(ADDR_CTRL_A, 8'h00);
		wr(ADDR_CTRL_A, 8'h01);
		@(posedge clk) harm <= 1'b1;
		cycles(60);
		chk(pin, 1'b0);
		@(posedge clk) harm <= 1'b0;
		wr(ADDR_CTRL_A, 8'h00);
		cycles(4);
		@(posedge clk) harm <= 1'b1;
		cycles(24);
		chk(pin, 1'b0);
		cycles(20);
		chk(pin, 1'b1);
		@(posedge clk) harm <= 1'b0;
		rd(ADDR_MISC, 8'h11);
		wait_loop(1'b0, 40000);
		cycles(2);
		chk(pin, 1'b0);
		rd(ADDR_MISC, 8'h10);
		wr(ADDR_CTRL_B, 8'h40);
		wr(ADDR_CTRL_B, 8'h00);
		cycles(2);
		rd(ADDR_MISC, 8'h00);
		wr(ADDR_CTRL_B, 8'h80);
		cycles(3);
		chk(pin, 1'b0);
		@(posedge clk) dinc <= 12'h44C;
		wait_loop(1'b1, 40000);
		chk(vco, VCO_BOTTOM);
		cycles(3);
		chk(pin, 1'b1);
		summarize();
	end
endmodule
